// File: cfd_config_fuse_decoder.sv
/*
 * configuration fuse decoder: samples the fuse word after reset,
 * holds it, and decodes it (osc select from the live word while switching is off) into controls for clock, flash,
 * watchdog, motor pwm, power-up and debug logic; apb slave on top.
 * assumes fuse word and osc/pll status are asynchronous levels.
 */
// Implementation choices: the APB slave port and the register offsets.
// What this block does
// - write-protect fuse zero blocks program writes
// - two-speed start runs fast rc first
// - decode three-bit initial oscillator source
// - switch mode gates switching and monitor
// - osc pin two: clock out or gpio
// - decode primary oscillator mode
// - watchdog fuse forces watchdog always on
// - fuse zero: software bit runs watchdog
// - window bit zero selects window mode
// - lock wait: pll switch waits lock
// - no lock wait: pll switch proceeds
// - prescaler bit picks 1:128 or 1:32
// - postscaler code doubles ratio per step
// - pwm pin mode at reset
// - high-side pwm polarity select
// - low-side pwm polarity select
// - power-up timer 2 to 128 ms
// - boundary scan port enable
// - debug channel pin pair select
// - sixteen postscale settings 1:1 upward
// - software watchdog bit cleared by reset
`timescale 1ns/1ps
module cfd_config_fuse_decoder
  import cfd_pkg::*;
#(
  parameter int PUD_MS_CYCLES = PUD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile fuse word and analog status
  input wire logic [31:0] nv_fuses,
  input wire logic osc_ready,
  input wire logic pll_lock,
  // program memory write gate
  input wire logic prog_wr_req,
  output logic prog_wr_grant,
  // clock controls
  output logic [2:0] active_osc_sel,
  output logic startup_on_selected,
  output logic clk_switch_en,
  output logic fail_safe_mon_en,
  output logic osc_pin2_clkout,
  output logic osc_pin2_gpio,
  output logic prim_osc_off,
  output logic prim_hs_xtal,
  output logic prim_std_xtal,
  output logic prim_ext_clk,
  input wire logic pll_switch_req,
  output logic pll_switch_go,
  // watchdog controls
  output logic wdog_run,
  output logic low_power_rc_en,
  output logic wdog_window_mode,
  output logic [7:0] wdog_prescale_ratio,
  output logic [15:0] wdog_postscale_ratio,
  // motor pwm
  output logic pwm_pins_port_ctrl,
  output logic pwm_high_active_high,
  output logic pwm_low_active_high,
  // power-up, scan and debug
  output logic powerup_done,
  output logic boundary_scan_port_en,
  output logic [2:0] debug_pair_sel
);

  // ************************************************************
  // helper functions
  // ************************************************************
  // postscale ratio, one doubling per code step
  function automatic logic [15:0] post_ratio(input logic [3:0] code);
    post_ratio = 16'h0001 << code;
  endfunction

  // power-up delay in ms, zero code means no delay
  function automatic logic [7:0] pud_ms(input logic [2:0] code);
    pud_ms = (code == 3'h0) ? 8'h00 : (8'h01 << code);
  endfunction

  // ************************************************************
  // input synchronisers and sampling
  // ************************************************************
  logic [33:0] sync1_reg;
  logic [33:0] sync2_reg;
  logic [31:0] shadow_reg;
  logic [31:0] shadow_next;
  logic cfg_valid_reg;
  logic [1:0] settle_reg;
  logic [31:0] pud_cnt_reg;
  logic [31:0] pud_cnt_next;
  logic [31:0] pud_target;
  logic switched_reg;
  logic wdog_sw_enable_reg;
  logic wdog_sw_enable_next;
  cfd_state_e state_reg;
  cfd_state_e state_next;
  wire [31:0] live_fuses = sync2_reg[31:0];
  wire osc_ready_s = sync2_reg[32];
  wire pll_lock_s = sync2_reg[33];

  // two flops for fuse word and analog status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {pll_lock, osc_ready, nv_fuses};
      sync2_reg <= sync1_reg;
    end
  end

  // ************************************************************
  // load sequencer
  // ************************************************************
  assign pud_target = 32'(pud_ms(shadow_reg[FB_PUD +: 3])) *
                      32'(PUD_MS_CYCLES);

  // next state: settle, load once, time power-up, then hold
  always_comb begin
    state_next = state_reg;
    shadow_next = shadow_reg;
    pud_cnt_next = pud_cnt_reg;
    case (state_reg)
      ST_SETTLE: begin
        if (settle_reg == SETTLE_CYCLES) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        shadow_next = live_fuses;
        pud_cnt_next = '0;
        state_next = ST_PUD;
      end
      ST_PUD: begin
        if (pud_cnt_reg >= pud_target) begin
          state_next = ST_READY;
        end else begin
          pud_cnt_next = pud_cnt_reg + 32'h0000_0001;
        end
      end
      ST_READY: state_next = ST_READY;
      default: state_next = ST_SETTLE;
    endcase
  end

  // sequencer state and held fuse word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_SETTLE;
      shadow_reg <= FUSE_RESET;
      pud_cnt_reg <= '0;
      settle_reg <= '0;
      cfg_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shadow_reg <= shadow_next;
      pud_cnt_reg <= pud_cnt_next;
      if (settle_reg != SETTLE_CYCLES) begin
        settle_reg <= settle_reg + 2'h1;
      end
      if (state_reg == ST_LOAD) begin
        cfg_valid_reg <= 1'b1;
      end
    end
  end

  assign powerup_done = (state_reg == ST_READY);

  // ************************************************************
  // clock source decode
  // ************************************************************
  wire [2:0] osc_sel_eff;
  wire crystal_mode;
  wire [1:0] posc = shadow_reg[FB_POSC +: 2];

  // switching enabled: held selection; otherwise live
  assign clk_switch_en = cfg_valid_reg & ~shadow_reg[FB_CKSM + 1];
  assign fail_safe_mon_en = clk_switch_en & ~shadow_reg[FB_CKSM];
  assign osc_sel_eff = clk_switch_en ? shadow_reg[FB_OSC +: 3] :
                       live_fuses[FB_OSC +: 3];

  // two-speed start: fast rc until selected source ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switched_reg <= 1'b0;
    end else if (cfg_valid_reg && (osc_ready_s ||
                 !shadow_reg[FB_TWOSPD])) begin
      switched_reg <= 1'b1;
    end
  end

  assign startup_on_selected = switched_reg;
  assign active_osc_sel = switched_reg ? osc_sel_eff : OSC_FAST_RC;

  // primary oscillator mode and pin two use
  assign prim_osc_off = cfg_valid_reg & (posc == POSC_OFF);
  assign prim_hs_xtal = cfg_valid_reg & (posc == POSC_HS);
  assign prim_std_xtal = cfg_valid_reg & (posc == POSC_XT);
  assign prim_ext_clk = cfg_valid_reg & (posc == POSC_EC);
  assign crystal_mode = prim_hs_xtal | prim_std_xtal;
  assign osc_pin2_clkout = cfg_valid_reg & ~crystal_mode &
                           shadow_reg[FB_OSC2FN];
  assign osc_pin2_gpio = cfg_valid_reg & ~crystal_mode &
                         ~shadow_reg[FB_OSC2FN];

  // pll switch gate on lock wait bit
  assign pll_switch_go = pll_switch_req & cfg_valid_reg &
                         (~shadow_reg[FB_LOCKWAIT] | pll_lock_s);

  // ************************************************************
  // flash, watchdog, pwm and debug decode
  // ************************************************************
  assign prog_wr_grant = prog_wr_req & cfg_valid_reg &
                         shadow_reg[FB_GWP];
  assign wdog_run = cfg_valid_reg & (shadow_reg[FB_WDTFUSE] |
                    wdog_sw_enable_reg);
  assign low_power_rc_en = wdog_run;
  assign wdog_window_mode = ~shadow_reg[FB_WINOFF];
  assign wdog_prescale_ratio = shadow_reg[FB_WDPRE] ?
                               WDOG_PRE_LONG : WDOG_PRE_SHORT;
  assign wdog_postscale_ratio =
    post_ratio(shadow_reg[FB_WDPOST +: 4]);
  assign pwm_pins_port_ctrl = shadow_reg[FB_PWMMODE];
  assign pwm_high_active_high = shadow_reg[FB_HIPOL];
  assign pwm_low_active_high = shadow_reg[FB_LOPOL];
  assign boundary_scan_port_en = cfg_valid_reg & shadow_reg[FB_JTAG];
  // reserved code selects no pair
  assign debug_pair_sel = !cfg_valid_reg ? 3'h0 :
    (shadow_reg[FB_DBGCH +: 2] == 2'h3) ? 3'h1 :
    (shadow_reg[FB_DBGCH +: 2] == 2'h2) ? 3'h2 :
    (shadow_reg[FB_DBGCH +: 2] == 2'h1) ? 3'h4 : 3'h0;

  // ************************************************************
  // apb slave
  // ************************************************************
  wire setup_ph = psel & ~penable;
  wire wr_take = psel & penable & pwrite & pready;
  wire hit_shadow = (paddr == REG_FUSE_SHADOW);
  wire hit_ctrl = (paddr == REG_WDOG_CTRL);
  wire hit_status = (paddr == REG_STATUS);
  wire addr_ok = hit_shadow | hit_ctrl | hit_status;
  wire [31:0] status_word = {24'h0000_00, pll_lock_s, active_osc_sel,
                             wdog_run, switched_reg, powerup_done,
                             cfg_valid_reg};
  wire [31:0] rd_mux = hit_shadow ? shadow_reg :
                       hit_ctrl ? {31'h0, wdog_sw_enable_reg} :
                       hit_status ? status_word : 32'h0000_0000;

  assign pready = 1'b1;
  // software enable bit, cleared by any reset
  assign wdog_sw_enable_next = (wr_take && hit_ctrl) ? pwdata[0] :
                               wdog_sw_enable_reg;

  // read data and error captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      wdog_sw_enable_reg <= 1'b0;
    end else begin
      wdog_sw_enable_reg <= wdog_sw_enable_next;
      if (setup_ph) begin
        prdata <= rd_mux;
        pslverr <= ~addr_ok;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_write_block: assert property (
    prog_wr_req && cfg_valid_reg && !shadow_reg[FB_GWP] |-> !prog_wr_grant)
    else $error("program write passed while protected");
  chk_two_speed: assert property (
    cfg_valid_reg && shadow_reg[FB_TWOSPD] && !switched_reg
    |-> active_osc_sel == OSC_FAST_RC)
    else $error("two-speed start not on fast rc");
  chk_monitor_gate: assert property (
    fail_safe_mon_en |-> clk_switch_en)
    else $error("monitor on without switching");
  chk_wdog_forced: assert property (
    cfg_valid_reg && shadow_reg[FB_WDTFUSE] |-> wdog_run && low_power_rc_en)
    else $error("watchdog stopped under fuse");
  chk_wdog_soft: assert property (
    cfg_valid_reg && !shadow_reg[FB_WDTFUSE] && wr_take && hit_ctrl
    |=> wdog_run == $past(pwdata[0]))
    else $error("software watchdog bit ignored");
  chk_pll_wait: assert property (
    pll_switch_go && shadow_reg[FB_LOCKWAIT] |-> pll_lock_s)
    else $error("pll switch before lock");
  chk_pll_nowait: assert property (
    pll_switch_req && cfg_valid_reg && !shadow_reg[FB_LOCKWAIT]
    |-> pll_switch_go)
    else $error("pll switch waited without lock wait");
  chk_post_onehot: assert property (
    $onehot(wdog_postscale_ratio) &&
    (wdog_postscale_ratio[15] == (shadow_reg[FB_WDPOST +: 4] == 4'hF)) &&
    (wdog_postscale_ratio[0] == (shadow_reg[FB_WDPOST +: 4] == 4'h0)))
    else $error("postscale ratio off its code");
  chk_pud_order: assert property (
    $rose(powerup_done) |-> $past(state_reg) == ST_PUD && cfg_valid_reg)
    else $error("power-up done out of order");
  chk_debug_pair: assert property (
    $onehot0(debug_pair_sel) && ((debug_pair_sel == 3'h0) ==
    (!cfg_valid_reg || shadow_reg[FB_DBGCH +: 2] == 2'h0)))
    else $error("debug pair off its code");
  chk_shadow_hold: assert property (
    cfg_valid_reg && $past(cfg_valid_reg) |-> $stable(shadow_reg))
    else $error("held fuse word changed");
  chk_sw_reset: assert property (
    $rose(cfg_valid_reg) |-> !wdog_sw_enable_reg || $past(wr_take))
    else $error("software watchdog bit not cleared");

  cov_two_speed: cover property (
    shadow_reg[FB_TWOSPD] && $rose(switched_reg));
  cov_pll_wait: cover property (
    pll_switch_req && !pll_switch_go ##1 pll_switch_go);
  cov_powerup: cover property ($rose(powerup_done));
  cov_sw_wdog: cover property (wr_take && hit_ctrl && pwdata[0]);

endmodule // cfd_config_fuse_decoder

// File: cfd_pkg.sv
/*
 * constants for the configuration fuse decoder: field layout of the
 * fuse word, reset values, register offsets, timing and osc codes.
 * assumes the fuse word arrives packed in this layout from storage.
 */
package cfd_pkg;

  // ************************************************************
  // fuse word field positions
  // ************************************************************
  localparam int FB_GWP = 0; // general segment write protect
  localparam int FB_TWOSPD = 1; // two-speed start-up
  localparam int FB_OSC = 2; // initial osc select, 3 bits
  localparam int FB_CKSM = 5; // clock switch/monitor mode, 2 bits
  localparam int FB_OSC2FN = 7; // osc pin two function
  localparam int FB_POSC = 8; // primary osc mode, 2 bits
  localparam int FB_WDTFUSE = 10;
  localparam int FB_WINOFF = 11;
  localparam int FB_LOCKWAIT = 12;
  localparam int FB_WDPRE = 13;
  localparam int FB_WDPOST = 14; // 4 bits
  localparam int FB_PWMMODE = 18;
  localparam int FB_HIPOL = 19;
  localparam int FB_LOPOL = 20;
  localparam int FB_PUD = 21; // 3 bits
  localparam int FB_JTAG = 24;
  localparam int FB_DBGCH = 25; // 2 bits

  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [31:0] FUSE_RESET = 32'hFFFF_FFFF; // erased state
  localparam logic [2:0] OSC_FAST_RC = 3'h0;
  localparam logic [1:0] POSC_HS = 2'h2;
  localparam logic [1:0] POSC_XT = 2'h1;
  localparam logic [1:0] POSC_EC = 2'h0;
  localparam logic [1:0] POSC_OFF = 2'h3;
  localparam logic [7:0] WDOG_PRE_LONG = 8'h80; // 1:128
  localparam logic [7:0] WDOG_PRE_SHORT = 8'h20; // 1:32
  localparam logic [1:0] SETTLE_CYCLES = 2'h2; // sync fill time

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int PUD_UNIT_MS = 1; // power-up timer step
  localparam int PUD_UNIT_CYCLES = PUD_UNIT_MS * CLK_FREQ_KHZ;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_FUSE_SHADOW = 8'h00; // ro
  localparam logic [7:0] REG_WDOG_CTRL = 8'h04; // rw, bit0
  localparam logic [7:0] REG_STATUS = 8'h08; // ro

  typedef enum logic [3:0] {
    ST_SETTLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_PUD = 4'b0100,
    ST_READY = 4'b1000
  } cfd_state_e;

endpackage

// File: cfd_fuse_model.sv
/*
 * fuse storage model: presents a programmed fuse word plus oscillator
 * ready and pll lock status to the decoder.
 * assumes the bench sets word and ready delay before releasing reset.
 */
`timescale 1ns/1ps
module cfd_fuse_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic [31:0] word_in,
  input wire logic [15:0] ready_delay,
  input wire logic lock_in,
  // storage side
  output logic [31:0] nv_fuses,
  output logic osc_ready,
  output logic pll_lock
);
  // ************************************************************
  // storage and status
  // ************************************************************
  logic [15:0] cnt_reg;
  // word as programmed, held at least through the load
  assign nv_fuses = word_in;
  assign pll_lock = lock_in;
  // oscillator ready after a chosen delay: prompt or slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      osc_ready <= 1'b0;
    end else begin
      if (cnt_reg != ready_delay) cnt_reg <= cnt_reg + 16'h0001;
      osc_ready <= (cnt_reg == ready_delay);
    end
  end
endmodule // cfd_fuse_model

// File: test_config_fuse_decoder.sv
/*
 * self-checking bench for the fuse decoder: random fuse words with
 * every code of the osc select, primary osc, postscale, power-up and debug fields forced in turn, apb register checks.
 * assumes the decoder contract: one wait-free apb access phase.
 */
`timescale 1ns/1ps
module test_config_fuse_decoder;
  import cfd_pkg::*;
  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam int PW = 10; // short millisecond for sim
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, nv_fuses, word, f, w, rd;
  logic osc_ready, pll_lock, lock, prog_wr_req, prog_wr_grant, er;
  logic startup_on_selected, clk_switch_en, fail_safe_mon_en;
  logic osc_pin2_clkout, osc_pin2_gpio, prim_osc_off, prim_hs_xtal;
  logic prim_std_xtal, prim_ext_clk, pll_switch_req, pll_switch_go;
  logic wdog_run, low_power_rc_en, wdog_window_mode, powerup_done;
  logic pwm_pins_port_ctrl, pwm_high_active_high, pwm_low_active_high;
  logic boundary_scan_port_en, xtal;
  logic [2:0] active_osc_sel, debug_pair_sel;
  logic [7:0] wdog_prescale_ratio;
  logic [15:0] wdog_postscale_ratio, dly;
  int err_count, checked, n, ms;
  cfd_config_fuse_decoder #(.PUD_MS_CYCLES(PW)) u_cfd_config_fuse_decoder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_fuses(nv_fuses),
    .osc_ready(osc_ready), .pll_lock(pll_lock),
    .prog_wr_req(prog_wr_req), .prog_wr_grant(prog_wr_grant),
    .active_osc_sel(active_osc_sel),
    .startup_on_selected(startup_on_selected),
    .clk_switch_en(clk_switch_en), .fail_safe_mon_en(fail_safe_mon_en),
    .osc_pin2_clkout(osc_pin2_clkout), .osc_pin2_gpio(osc_pin2_gpio),
    .prim_osc_off(prim_osc_off), .prim_hs_xtal(prim_hs_xtal),
    .prim_std_xtal(prim_std_xtal), .prim_ext_clk(prim_ext_clk),
    .pll_switch_req(pll_switch_req), .pll_switch_go(pll_switch_go),
    .wdog_run(wdog_run), .low_power_rc_en(low_power_rc_en),
    .wdog_window_mode(wdog_window_mode),
    .wdog_prescale_ratio(wdog_prescale_ratio),
    .wdog_postscale_ratio(wdog_postscale_ratio),
    .pwm_pins_port_ctrl(pwm_pins_port_ctrl),
    .pwm_high_active_high(pwm_high_active_high),
    .pwm_low_active_high(pwm_low_active_high),
    .powerup_done(powerup_done),
    .boundary_scan_port_en(boundary_scan_port_en),
    .debug_pair_sel(debug_pair_sel));
  cfd_fuse_model u_cfd_fuse_model (.pclk(pclk), .presetn(presetn),
    .word_in(word), .ready_delay(dly), .lock_in(lock),
    .nv_fuses(nv_fuses), .osc_ready(osc_ready), .pll_lock(pll_lock));
  // ************************************************************
  // helpers
  // ************************************************************
  always #4 pclk = ~pclk;
  // xorshift source of fuse words
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
  // ************************************************************
  // main sequence: one reset and fuse word per run
  // ************************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000; lock = 1'b0;
    prog_wr_req = 1'b0; pll_switch_req = 1'b0; word = 32'h0000_0000;
    dly = 16'h0000; err_count = 0; checked = 0; w = 32'h0000_0012;
    for (int i = 0; i < 16; i++) begin
      w = xs(w);
      f = w;
      f[4:2] = i[2:0];
      f[9:8] = i[1:0];
      f[17:14] = i[3:0];
      f[23:21] = i[2:0];
      f[26:25] = i[1:0];
      word <= f;
      dly <= i[0] ? 16'd1400 : 16'd0;
      lock <= 1'b0;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      while (powerup_done !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      ms = (f[23:21] == 3'h0) ? 0 : (1 << f[23:21]);
      // sync fill, settle, load, then one edge past the count
      chk(n, ms * PW + 6);
      if (i[0] && f[1]) begin
        chk(active_osc_sel, 0);
        chk(startup_on_selected, 0);
      end
      n = 0;
      while (startup_on_selected !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk(startup_on_selected, 1);
      chk(active_osc_sel, f[4:2]);
      xtal = (f[9:8] == 2'h1) || (f[9:8] == 2'h2);
      chk(clk_switch_en, !f[6]);
      chk(fail_safe_mon_en, f[6:5] == 2'h0);
      chk(osc_pin2_clkout, !xtal && f[7]);
      chk(osc_pin2_gpio, !xtal && !f[7]);
      chk({prim_osc_off, prim_hs_xtal, prim_std_xtal, prim_ext_clk},
          4'h1 << f[9:8]);
      chk(wdog_run, f[10]);
      chk(low_power_rc_en, f[10]);
      chk(wdog_window_mode, !f[11]);
      chk(wdog_prescale_ratio, f[13] ? 128 : 32);
      chk(wdog_postscale_ratio, 1 << f[17:14]);
      chk({pwm_low_active_high, pwm_high_active_high,
           pwm_pins_port_ctrl}, f[20:18]);
      chk(boundary_scan_port_en, f[24]);
      chk(debug_pair_sel,
          f[26:25] == 2'h0 ? 0 : 3'h1 << (3 - f[26:25]));
      @(posedge pclk);
      prog_wr_req <= 1'b1;
      pll_switch_req <= 1'b1;
      @(posedge pclk);
      chk(prog_wr_grant, f[0]);
      chk(pll_switch_go, !f[12]);
      lock <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pll_switch_go, 1);
      prog_wr_req <= 1'b0;
      pll_switch_req <= 1'b0;
      apb(1'b0, REG_WDOG_CTRL, 32'h0000_0000);
      chk(rd, 0);
      apb(1'b1, REG_FUSE_SHADOW, ~f);
      apb(1'b0, REG_FUSE_SHADOW, 32'h0000_0000);
      chk(rd, f);
      apb(1'b1, REG_WDOG_CTRL, 32'h0000_0001);
      @(posedge pclk);
      chk(wdog_run, 1);
      apb(1'b1, REG_WDOG_CTRL, 32'h0000_0000);
      @(posedge pclk);
      chk(wdog_run, f[10]);
      apb(1'b1, REG_WDOG_CTRL, 32'h0000_0001);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(er, 1);
      chk(rd, 0);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(rd[2:0], 3'h7);
      // live source bits apply after the two sync flops only while switching is off
      word <= f ^ 32'h0000_001C;
      repeat (3) @(posedge pclk);
      chk(active_osc_sel, {29'h0000_0000, f[4:2] ^ {3{f[6]}}});
      $display("run %0d done", i);
    end
    report_and_stop();
  end
endmodule // test_config_fuse_decoder
